// *** design/pio_pkg.sv ***
package pio_pkg;

   // ==========================================================
   // register map (byte addresses)
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_IN_CFG = 8'h04;
   localparam logic [7:0] ADDR_OUT_CFG = 8'h08;
   localparam logic [7:0] ADDR_DOUT = 8'h0c;
   localparam logic [7:0] ADDR_DIN = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   localparam logic [7:0] ADDR_MASK = 8'h18;
   localparam logic [7:0] ADDR_PACE_DIV = 8'h1c;

   // ==========================================================
   // field positions
   localparam int CTRL_DIR_LSB = 0;
   localparam int CTRL_BM_BIT = 2;
   localparam int CFG_SRC_LSB = 0;
   localparam int CFG_START_EN = 2;
   localparam int CFG_START_RISE = 3;
   localparam int CFG_STOP_EN = 4;
   localparam int CFG_STOP_RISE = 5;
   localparam int CFG_SW_START = 6;
   localparam int CFG_SW_STOP = 7;
   localparam int CFG_RUN_BIT = 8;
   localparam int ST_LINE_LSB = 0;
   localparam int ST_IN_STOP = 4;
   localparam int ST_OUT_STOP = 5;
   localparam int ST_W = 6;

   // ==========================================================
   // encodings
   typedef logic [1:0] pio_dir_t;
   localparam pio_dir_t ALL_INPUT_SETTING = 2'h0;
   localparam pio_dir_t SPLIT_DIRECTION_SETTING = 2'h1;
   localparam pio_dir_t ALL_OUTPUT_SETTING = 2'h2;
   typedef logic [1:0] pio_src_t;
   localparam pio_src_t SRC_INTERNAL = 2'h0;
   localparam pio_src_t SRC_EXTERNAL = 2'h1;
   localparam pio_src_t SRC_HANDSHAKE = 2'h2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ==========================================================
   // reset values
   localparam logic [2:0] CTRL_RST = 3'h0;
   localparam logic [5:0] CFG_RST = 6'h00;
   localparam logic [15:0] PACE_DIV_RST = 16'h0063;

   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int IN_REQ_MIN_NS = 50;
   localparam int IN_ACK_NS = 100;
   localparam int OUT_REQ_NS = 100;
   localparam int OUT_ACK_MIN_NS = 25;
   // low widths in clock cycles: thresholds for request and ack inputs, pulse lengths for ack and request outputs
   localparam int IN_REQ_CYC = (IN_REQ_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int IN_ACK_CYC = IN_ACK_NS / CLK_PERIOD_NS;
   localparam int OUT_REQ_CYC = OUT_REQ_NS / CLK_PERIOD_NS;
   localparam int OUT_ACK_CYC = (OUT_ACK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : pio_pkg

// *** design/pio_sync.sv ***
// two-flop synchroniser with edge detect
module pio_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // asynchronous inputs
   input wire logic [W-1:0] async_i,
   // synchronised level and edges
   output logic [W-1:0] level_o,
   output logic [W-1:0] rise_o,
   output logic [W-1:0] fall_o
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;
   logic [W-1:0] prev_q;

   initial begin
      if (W < 1) $error("pio_sync W below 1");
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         meta_q <= '0;
         sync_q <= '0;
         prev_q <= '0;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign level_o = sync_q;
   assign rise_o = sync_q & ~prev_q;
   assign fall_o = ~sync_q & prev_q;

endmodule : pio_sync

// *** design/pio_ctrl.sv ***
// What this block does
// - three direction settings for four groups
// - same directions for general I/O and transfer
// - rising-edge interrupts on group A lines 0-3, general I/O mode with group A input only
// - separate control sets for input and output
// - device drives input ack and output request
// - external clock steps on its falling edge
// - selectable start edge begins transfer
// - selectable stop edge ends transfer
// - request and acknowledge are active low
// - capture input after request low over 50 ns
// - acknowledge input word after host write completes
// - input acknowledge low for 100 ns
// - output request low pulse of 100 ns
// - output ack over 25 ns ends transfer
module pio_ctrl
   import pio_pkg::*;
#(
   parameter int AW = 8,
   parameter int DIV_W = 16
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // axi4-lite slave
   input wire logic [AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // interrupt
   output logic irq,
   // pattern lines
   input wire logic [7:0] group_a_lines_i,
   output logic [7:0] group_a_lines_o,
   output logic group_a_lines_oe_n,
   input wire logic [7:0] group_b_lines_i,
   output logic [7:0] group_b_lines_o,
   output logic group_b_lines_oe_n,
   input wire logic [7:0] group_c_lines_i,
   output logic [7:0] group_c_lines_o,
   output logic group_c_lines_oe_n,
   input wire logic [7:0] group_d_lines_i,
   output logic [7:0] group_d_lines_o,
   output logic group_d_lines_oe_n,
   // control pins
   input wire logic in_pacer_clock,
   input wire logic out_pacer_clock,
   input wire logic in_start_trigger,
   input wire logic out_start_trigger,
   input wire logic in_stop_trigger,
   input wire logic out_stop_trigger,
   input wire logic in_request_n,
   output logic in_acknowledge_n,
   output logic out_request_n,
   input wire logic out_acknowledge_n,
   // bus-master engine, input words to host memory
   output logic in_word_valid,
   output logic [31:0] in_word_data,
   input wire logic in_word_done,
   // bus-master engine, output words from host memory
   output logic out_word_req,
   input wire logic out_word_valid,
   input wire logic [31:0] out_word_data
);
   initial begin
      if (AW < 8 || AW > 32) $error("pio_ctrl bad AW");
      if (DIV_W < 1 || DIV_W > 16) $error("pio_ctrl bad DIV_W");
   end

   // ==========================================================
   // synchronisers
   logic [7:0] ctl_lvl;
   logic [7:0] ctl_rise;
   logic [7:0] ctl_fall;
   logic [31:0] pins_lvl;
   logic [31:0] pins_rise;

   pio_sync #(.W(8)) u_ctl_sync (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .async_i({out_acknowledge_n, in_request_n, out_stop_trigger, in_stop_trigger,
                out_start_trigger, in_start_trigger, out_pacer_clock, in_pacer_clock}),
      .level_o(ctl_lvl),
      .rise_o(ctl_rise),
      .fall_o(ctl_fall)
   );

   pio_sync #(.W(32)) u_pin_sync (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .async_i({group_d_lines_i, group_c_lines_i, group_b_lines_i, group_a_lines_i}),
      .level_o(pins_lvl),
      .rise_o(pins_rise),
      .fall_o()
   );

   // ==========================================================
   // registers
   logic [2:0] ctrl_q;
   logic [5:0] in_cfg_q;
   logic [5:0] out_cfg_q;
   logic [31:0] dout_q;
   logic [ST_W-1:0] status_q;
   logic [ST_W-1:0] mask_q;
   logic [15:0] pace_div_q;
   logic in_run_q;
   logic out_run_q;
   logic aw_have_q;
   logic w_have_q;
   logic [AW-1:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic wr_en;
   logic [31:0] wr_val;
   logic [31:0] rd_val;
   logic rd_hit;
   logic wr_hit;
   logic in_sw_start;
   logic in_sw_stop;
   logic out_sw_start;
   logic out_sw_stop;
   logic [ST_W-1:0] st_set;
   logic [ST_W-1:0] st_clr;
   pio_dir_t dir;
   logic bm_mode;

   assign dir = ctrl_q[CTRL_DIR_LSB +: 2];
   assign bm_mode = ctrl_q[CTRL_BM_BIT];
   assign wr_en = aw_have_q && w_have_q && !s_axi_bvalid;

   always_comb begin
      wr_val = '0;
      for (int i = 0; i < 4; i++) begin
         wr_val[8*i +: 8] = w_strb_q[i] ? w_data_q[8*i +: 8] : 8'h00;
      end
   end

   always_comb begin
      unique case (aw_addr_q[7:0] & 8'hfc)
         ADDR_CTRL, ADDR_IN_CFG, ADDR_OUT_CFG, ADDR_DOUT, ADDR_DIN,
         ADDR_STATUS, ADDR_MASK, ADDR_PACE_DIV: wr_hit = (aw_addr_q[AW-1:2] >> 6) == '0;
         default: wr_hit = 1'b0;
      endcase
   end

   always_comb begin
      rd_hit = (s_axi_araddr[AW-1:2] >> 6) == '0;
      unique case (s_axi_araddr[7:0] & 8'hfc)
         ADDR_CTRL: rd_val = {29'h0, ctrl_q};
         ADDR_IN_CFG: rd_val = {23'h0, in_run_q, 2'h0, in_cfg_q};
         ADDR_OUT_CFG: rd_val = {23'h0, out_run_q, 2'h0, out_cfg_q};
         ADDR_DOUT: rd_val = dout_q;
         ADDR_DIN: rd_val = pins_lvl;
         ADDR_STATUS: rd_val = {{(32-ST_W){1'b0}}, status_q};
         ADDR_MASK: rd_val = {{(32-ST_W){1'b0}}, mask_q};
         ADDR_PACE_DIV: rd_val = {16'h0, pace_div_q};
         default: begin
            rd_val = '0;
            rd_hit = 1'b0;
         end
      endcase
   end

   // write channel: address and data taken in either order
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_addr_q <= '0;
         w_data_q <= '0;
         w_strb_q <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end else if (!aw_have_q && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end else if (!w_have_q && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
         end
         if (wr_en) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // read channel
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
         end
      end
   end

   // software-written configuration
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_q <= CTRL_RST;
         in_cfg_q <= CFG_RST;
         out_cfg_q <= CFG_RST;
         dout_q <= '0;
         mask_q <= '0;
         pace_div_q <= PACE_DIV_RST;
      end else if (wr_en) begin
         unique case (aw_addr_q[7:0] & 8'hfc)
            ADDR_CTRL: ctrl_q <= wr_val[2:0];
            ADDR_IN_CFG: in_cfg_q <= wr_val[5:0];
            ADDR_OUT_CFG: out_cfg_q <= wr_val[5:0];
            ADDR_DOUT: dout_q <= wr_val;
            ADDR_MASK: mask_q <= wr_val[ST_W-1:0];
            ADDR_PACE_DIV: pace_div_q <= wr_val[15:0];
            default: ;
         endcase
      end
   end

   assign in_sw_start = wr_en && (aw_addr_q[7:0] & 8'hfc) == ADDR_IN_CFG && wr_val[CFG_SW_START];
   assign in_sw_stop = wr_en && (aw_addr_q[7:0] & 8'hfc) == ADDR_IN_CFG && wr_val[CFG_SW_STOP];
   assign out_sw_start = wr_en && (aw_addr_q[7:0] & 8'hfc) == ADDR_OUT_CFG && wr_val[CFG_SW_START];
   assign out_sw_stop = wr_en && (aw_addr_q[7:0] & 8'hfc) == ADDR_OUT_CFG && wr_val[CFG_SW_STOP];
   assign st_clr = (wr_en && (aw_addr_q[7:0] & 8'hfc) == ADDR_STATUS) ? wr_val[ST_W-1:0] : '0;

   // ==========================================================
   // start / stop and pacing, one set per direction
   logic in_start_hit;
   logic in_stop_hit;
   logic out_start_hit;
   logic out_stop_hit;
   logic in_tick;
   logic out_tick;
   logic [DIV_W-1:0] in_div_q;
   logic [DIV_W-1:0] out_div_q;
   pio_src_t in_src;
   pio_src_t out_src;

   assign in_src = in_cfg_q[CFG_SRC_LSB +: 2];
   assign out_src = out_cfg_q[CFG_SRC_LSB +: 2];
   assign in_start_hit = in_cfg_q[CFG_START_EN] && (in_cfg_q[CFG_START_RISE] ? ctl_rise[2] : ctl_fall[2]);
   assign out_start_hit = out_cfg_q[CFG_START_EN] && (out_cfg_q[CFG_START_RISE] ? ctl_rise[3] : ctl_fall[3]);
   assign in_stop_hit = in_cfg_q[CFG_STOP_EN] && (in_cfg_q[CFG_STOP_RISE] ? ctl_rise[4] : ctl_fall[4]);
   assign out_stop_hit = out_cfg_q[CFG_STOP_EN] && (out_cfg_q[CFG_STOP_RISE] ? ctl_rise[5] : ctl_fall[5]);

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         in_run_q <= 1'b0;
         out_run_q <= 1'b0;
      end else begin
         if (!bm_mode || in_stop_hit || in_sw_stop) in_run_q <= 1'b0;
         else if (in_start_hit || in_sw_start) in_run_q <= 1'b1;
         if (!bm_mode || out_stop_hit || out_sw_stop) out_run_q <= 1'b0;
         else if (out_start_hit || out_sw_start) out_run_q <= 1'b1;
      end
   end

   // internal pacer: one tick every pace_div+1 cycles
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         in_div_q <= '0;
         out_div_q <= '0;
      end else begin
         in_div_q <= (!in_run_q || in_div_q == '0) ? pace_div_q[DIV_W-1:0] : in_div_q - 1'b1;
         out_div_q <= (!out_run_q || out_div_q == '0) ? pace_div_q[DIV_W-1:0] : out_div_q - 1'b1;
      end
   end

   assign in_tick = (in_src == SRC_EXTERNAL) ? ctl_fall[0] : (in_src == SRC_INTERNAL && in_div_q == '0);
   assign out_tick = (out_src == SRC_EXTERNAL) ? ctl_fall[1] : (out_src == SRC_INTERNAL && out_div_q == '0);

   // ==========================================================
   // pattern input
   typedef enum logic [3:0] {
      IH_ARM = 4'b0001,
      IH_COUNT = 4'b0010,
      IH_BUSY = 4'b0100,
      IH_ACK = 4'b1000
   } pio_ih_t;
   pio_ih_t ih_q;
   logic [3:0] ih_cnt_q;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ih_q <= IH_ARM;
         ih_cnt_q <= '0;
         in_word_valid <= 1'b0;
         in_word_data <= '0;
         in_acknowledge_n <= 1'b1;
      end else begin
         in_word_valid <= 1'b0;
         if (!in_run_q || in_src != SRC_HANDSHAKE) begin
            ih_q <= IH_ARM;
            ih_cnt_q <= '0;
            in_acknowledge_n <= 1'b1;
            if (in_run_q && in_tick) begin
               in_word_valid <= 1'b1;
               in_word_data <= pins_lvl;
            end
         end else begin
            unique case (ih_q)
               // wait for request released, so one long low is one word
               IH_ARM: begin
                  ih_cnt_q <= '0;
                  if (ctl_lvl[6]) ih_q <= IH_COUNT;
               end
               IH_COUNT: begin
                  if (ctl_lvl[6]) begin
                     ih_cnt_q <= '0;
                  end else if (ih_cnt_q == 4'(IN_REQ_CYC)) begin
                     in_word_valid <= 1'b1;
                     in_word_data <= pins_lvl;
                     ih_q <= IH_BUSY;
                  end else begin
                     ih_cnt_q <= ih_cnt_q + 4'h1;
                  end
               end
               IH_BUSY: begin
                  ih_cnt_q <= '0;
                  if (in_word_done) begin
                     in_acknowledge_n <= 1'b0;
                     ih_q <= IH_ACK;
                  end
               end
               IH_ACK: begin
                  if (ih_cnt_q == 4'(IN_ACK_CYC - 1)) begin
                     in_acknowledge_n <= 1'b1;
                     ih_q <= IH_ARM;
                  end else begin
                     ih_cnt_q <= ih_cnt_q + 4'h1;
                  end
               end
            endcase
         end
      end
   end

   // ==========================================================
   // pattern output
   typedef enum logic [2:0] {
      OH_IDLE = 3'b001,
      OH_REQ = 3'b010,
      OH_ACK = 3'b100
   } pio_oh_t;
   pio_oh_t oh_q;
   logic [3:0] oh_cnt_q;
   logic [31:0] out_word_q;
   logic [31:0] pend_q;
   logic pend_q_v;
   logic fetch_q;
   logic want_q;
   logic load_word;
   logic hs_out;

   assign hs_out = out_src == SRC_HANDSHAKE;
   assign load_word = out_run_q && pend_q_v && (hs_out ? (oh_q == OH_IDLE) : out_tick);

   // fetch words from host memory, one outstanding at a time
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         out_word_req <= 1'b0;
         fetch_q <= 1'b0;
         want_q <= 1'b0;
         pend_q <= '0;
         pend_q_v <= 1'b0;
         out_word_q <= '0;
      end else begin
         out_word_req <= 1'b0;
         if (!out_run_q) want_q <= 1'b1;
         else if (oh_q == OH_ACK && ctl_fall[7]) want_q <= 1'b1;
         else if (out_word_req) want_q <= 1'b0;
         if (out_run_q && !pend_q_v && !fetch_q && !out_word_req && (want_q || !hs_out)) begin
            out_word_req <= 1'b1;
            fetch_q <= 1'b1;
         end
         if (out_word_valid && fetch_q) begin
            fetch_q <= 1'b0;
            pend_q <= out_word_data;
            pend_q_v <= 1'b1;
         end else if (load_word || !out_run_q) begin
            pend_q_v <= 1'b0;
         end
         if (load_word) out_word_q <= pend_q;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         oh_q <= OH_IDLE;
         oh_cnt_q <= '0;
         out_request_n <= 1'b1;
      end else if (!out_run_q || !hs_out) begin
         oh_q <= OH_IDLE;
         oh_cnt_q <= '0;
         out_request_n <= 1'b1;
      end else begin
         unique case (oh_q)
            OH_IDLE: begin
               oh_cnt_q <= '0;
               if (load_word) begin
                  out_request_n <= 1'b0;
                  oh_q <= OH_REQ;
               end
            end
            OH_REQ: begin
               if (oh_cnt_q == 4'(OUT_REQ_CYC - 1)) begin
                  out_request_n <= 1'b1;
                  oh_cnt_q <= '0;
                  oh_q <= OH_ACK;
               end else begin
                  oh_cnt_q <= oh_cnt_q + 4'h1;
               end
            end
            OH_ACK: begin
               if (ctl_lvl[7]) begin
                  oh_cnt_q <= '0;
               end else if (oh_cnt_q == 4'(OUT_ACK_CYC - 1)) begin
                  oh_q <= OH_IDLE;
               end else begin
                  oh_cnt_q <= oh_cnt_q + 4'h1;
               end
            end
         endcase
      end
   end

   // ==========================================================
   // pins, status and interrupt
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         {group_d_lines_o, group_c_lines_o, group_b_lines_o, group_a_lines_o} <= '0;
         group_a_lines_oe_n <= 1'b1;
         group_b_lines_oe_n <= 1'b1;
         group_c_lines_oe_n <= 1'b1;
         group_d_lines_oe_n <= 1'b1;
      end else begin
         {group_d_lines_o, group_c_lines_o, group_b_lines_o, group_a_lines_o} <= bm_mode ? out_word_q : dout_q;
         group_a_lines_oe_n <= dir != ALL_OUTPUT_SETTING;
         group_b_lines_oe_n <= dir != ALL_OUTPUT_SETTING;
         group_c_lines_oe_n <= dir != ALL_OUTPUT_SETTING && dir != SPLIT_DIRECTION_SETTING;
         group_d_lines_oe_n <= dir != ALL_OUTPUT_SETTING && dir != SPLIT_DIRECTION_SETTING;
      end
   end

   always_comb begin
      st_set = '0;
      if (!bm_mode && (dir == ALL_INPUT_SETTING || dir == SPLIT_DIRECTION_SETTING)) begin
         st_set[ST_LINE_LSB +: 4] = pins_rise[3:0];
      end
      st_set[ST_IN_STOP] = in_run_q && (in_stop_hit || in_sw_stop);
      st_set[ST_OUT_STOP] = out_run_q && (out_stop_hit || out_sw_stop);
   end

   // set wins over a simultaneous write-one clear
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         status_q <= '0;
         irq <= 1'b0;
      end else begin
         status_q <= (status_q & ~st_clr) | st_set;
         irq <= |(((status_q & ~st_clr) | st_set) & mask_q);
      end
   end

endmodule : pio_ctrl

// *** tb/pio_ctrl_assertions.sv ***
module pio_chk (
   // clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // watched outputs and engine input
   input wire logic group_a_lines_oe_n,
   input wire logic group_b_lines_oe_n,
   input wire logic group_c_lines_oe_n,
   input wire logic group_d_lines_oe_n,
   input wire logic in_acknowledge_n,
   input wire logic in_word_done,
   input wire logic in_word_valid,
   input wire logic out_request_n,
   input wire logic out_word_req
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   dir_ab_a: assert property (group_a_lines_oe_n == group_b_lines_oe_n) else $error("a b dir");
   dir_cd_a: assert property (group_c_lines_oe_n == group_d_lines_oe_n) else $error("c d dir");
   dir_order_a: assert property (!group_a_lines_oe_n |-> !group_c_lines_oe_n) else $error("a out c in");
   ack_width_a: assert property ($fell(in_acknowledge_n) |-> ##9 !in_acknowledge_n ##1 in_acknowledge_n)
      else $error("ack width");
   ack_cause_a: assert property ($fell(in_acknowledge_n) |-> $past(in_word_done)) else $error("ack early");
   req_width_a: assert property ($fell(out_request_n) |-> ##9 !out_request_n ##1 out_request_n)
      else $error("req width");
   cap_pulse_a: assert property (in_word_valid |=> !in_word_valid) else $error("capture long");
   next_pulse_a: assert property (out_word_req |=> !out_word_req) else $error("word req long");
   cover property ($fell(in_acknowledge_n));
   cover property ($fell(out_request_n));
   cover property (group_a_lines_oe_n && !group_c_lines_oe_n);
endmodule : pio_chk

bind pio_ctrl pio_chk i_pio_chk (.*);

// *** tb/pio_far.sv ***
module pio_far (
   // handshake pins
   input wire logic out_request_n,
   output logic in_request_n,
   output logic out_acknowledge_n
);
   timeunit 1ns;
   timeprecision 100ps;
   int ack_dly;
   initial begin
      in_request_n = 1;
      out_acknowledge_n = 1;
   end
   // acknowledge each output word once its request ends
   always @(negedge out_request_n) begin
      @(posedge out_request_n);
      #(ack_dly) out_acknowledge_n = 0;
      #40 out_acknowledge_n = 1;
   end
   task send(input int w);
      #3 in_request_n = 0;
      #(w) in_request_n = 1;
   endtask : send
endmodule : pio_far

// *** tb/pio_ctrl_test.sv ***
module pio_ctrl_test;
   timeunit 1ns;
   timeprecision 100ps;
   import pio_pkg::*;
   logic clk_sys = 0, arst_n = 0, irq;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, pat = 0, in_word_data, out_word_data = 0, rdat;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp, rrsp;
   logic [7:0] group_a_lines_i, group_b_lines_i, group_c_lines_i, group_d_lines_i;
   logic [7:0] group_a_lines_o, group_b_lines_o, group_c_lines_o, group_d_lines_o;
   logic group_a_lines_oe_n, group_b_lines_oe_n, group_c_lines_oe_n, group_d_lines_oe_n;
   logic in_pacer_clock = 1, out_pacer_clock = 1, in_start_trigger = 0, out_start_trigger = 0;
   logic in_stop_trigger = 0, out_stop_trigger = 0, in_request_n, in_acknowledge_n;
   logic out_request_n, out_acknowledge_n, in_word_valid, in_word_done = 0, out_word_req, out_word_valid = 0;
   logic [5:0] rows [4] = '{6'h0f, 6'h1c, 6'h20, 6'h3f};
   int dly [2] = '{23, 303};
   int mismatches = 0, total_checks = 0, n_in = 0, n_ack = 0, n_req = 0, n_oack = 0, n0;
   assign {group_d_lines_i, group_c_lines_i, group_b_lines_i, group_a_lines_i} = pat;
   pio_ctrl i_pio_ctrl (.*);
   pio_far i_pio_far (.*);
   initial forever #5 clk_sys = ~clk_sys;
   // host memory engine: prompt answers
   always @(posedge clk_sys) begin
      in_word_done <= in_word_valid;
      out_word_valid <= out_word_req;
      out_word_data <= out_word_data + 1;
      if (in_word_valid) n_in++;
   end
   always @(negedge in_acknowledge_n) n_ack++;
   always @(negedge out_request_n) n_req++;
   always @(negedge out_acknowledge_n) n_oack++;
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: %h vs %h", $time, seen, exp);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, w;
      aw = 1;
      w = 1;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(posedge clk_sys);
         aw = aw & !s_axi_awready;
         w = w & !s_axi_wready;
         s_axi_awvalid <= aw;
         s_axi_wvalid <= w;
      end while (aw | w);
      do @(posedge clk_sys); while (!s_axi_bvalid);
      chk(s_axi_bresp, RESP_OKAY);
      s_axi_bready <= 0;
   endtask : wr
   task rd(input logic [7:0] a);
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do @(posedge clk_sys); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      do @(posedge clk_sys); while (!s_axi_rvalid);
      s_axi_rready <= 0;
      rdat = s_axi_rdata;
      rrsp = s_axi_rresp;
   endtask : rd
   task complete_run;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : complete_run
   task wait_run(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : wait_run
   initial begin
      #100000;
      mismatches++;
      complete_run;
   end
   initial begin
      wait_run(20);
      arst_n <= 1;
      rd(ADDR_PACE_DIV);
      chk(rdat, 32'h63);
      for (int i = 0; i < 8; i++) begin
         wr(ADDR_CTRL, {29'h0, i[2], rows[i % 4][5:4]});
         wait_run(2);
         chk({group_a_lines_oe_n, group_b_lines_oe_n, group_c_lines_oe_n, group_d_lines_oe_n}, rows[i % 4][3:0]);
      end
      $display("directions done");
      wr(ADDR_CTRL, 32'h0);
      wr(ADDR_STATUS, 32'h3f);
      wr(ADDR_MASK, 32'hf);
      pat <= 32'h1;
      wait_run(8);
      chk(irq, 1);
      wr(ADDR_STATUS, 32'h1);
      wait_run(2);
      chk(irq, 0);
      wr(ADDR_MASK, 32'h0);
      pat <= 32'h3;
      wait_run(8);
      chk(irq, 0);
      rd(ADDR_STATUS);
      chk(rdat[3:0], 4'h2);
      wr(ADDR_CTRL, 32'h2);
      wr(ADDR_STATUS, 32'h3f);
      wr(ADDR_MASK, 32'hf);
      wr(ADDR_DOUT, 32'h1234);
      pat <= 32'h7;
      wait_run(8);
      chk(irq, 0);
      chk(group_b_lines_o, 8'h12);
      rd(8'h20);
      chk(rrsp, RESP_SLVERR);
      $display("interrupts done");
      wr(ADDR_CTRL, 32'h4);
      wr(ADDR_IN_CFG, 32'h42);
      pat <= 32'h5a5a5a5a;
      n0 = n_in;
      i_pio_far.send(30);
      wait_run(12);
      chk(n_in - n0, 0);
      i_pio_far.send(80);
      wait_run(30);
      chk(n_in - n0, 1);
      chk(in_word_data, 32'h5a5a5a5a);
      chk(n_ack, 1);
      $display("input handshake done");
      wr(ADDR_IN_CFG, 32'h80);
      wr(ADDR_IN_CFG, 32'h41);
      wait_run(4);
      n0 = n_in;
      #3;
      repeat (10) begin
         #40 in_pacer_clock = 0;
         #40 in_pacer_clock = 1;
      end
      wait_run(6);
      chk(n_in - n0, 10);
      wr(ADDR_IN_CFG, 32'h80);
      wr(ADDR_IN_CFG, 32'h1c);
      wr(ADDR_STATUS, 32'h3f);
      in_start_trigger <= 1;
      wait_run(6);
      rd(ADDR_IN_CFG);
      chk(rdat[8], 1);
      in_stop_trigger <= 1;
      wait_run(6);
      rd(ADDR_IN_CFG);
      chk(rdat[8], 1);
      in_stop_trigger <= 0;
      wait_run(6);
      rd(ADDR_IN_CFG);
      chk(rdat[8], 0);
      in_start_trigger <= 0;
      wait_run(6);
      rd(ADDR_STATUS);
      chk(rdat[4], 1);
      rd(ADDR_IN_CFG);
      chk(rdat[8], 0);
      $display("pacing done");
      wr(ADDR_CTRL, 32'h6);
      wr(ADDR_OUT_CFG, 32'h42);
      foreach (dly[k]) begin
         i_pio_far.ack_dly = dly[k];
         wait_run(100);
         chk(n_req - n_oack <= 1, 1);
      end
      chk(n_req > 2, 1);
      $display("output handshake done");
      complete_run;
   end
endmodule : pio_ctrl_test
